//--- csl_pkg.sv
`default_nettype none
package csl_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PAGE_WORDS = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned N_PINS = 5;
  localparam int unsigned N_CH = 4;
  // APB register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_GCFG = 8'h08;
  localparam logic [7:0] OFF_PINDIR = 8'h0C;
  localparam logic [7:0] OFF_PINFN = 8'h10;
  localparam logic [7:0] OFF_DIV = 8'h14;
  localparam logic [7:0] OFF_PRESC = 8'h18;
  // Layout of general_config_word_a (word 0 of a page).
  localparam int unsigned GCFG_MODE_BIT = 0;
  localparam int unsigned GCFG_HOLD_EN_BIT = 1;
  localparam int unsigned GCFG_DIR_LSB = 2;
  localparam int unsigned GCFG_FN_LSB = 7;
  // Page word indices.
  localparam logic [3:0] W_GCFG = 4'h0;
  localparam logic [3:0] W_DIV_LSB = 4'h1;
  localparam logic [3:0] W_PRESC = 4'h5;
  localparam logic [WORD_W-1:0] GCFG_RESET = 16'h0002;
  localparam int unsigned DIV_W = 14;
  localparam int unsigned PRESC_W = 2;
  localparam int unsigned CTRL_RELOAD_BIT = 0;
  localparam int unsigned CTRL_MUTE_FORCE_BIT = 1;
  localparam logic [3:0] SYNC_CYCLES = 4'h4;
  typedef enum logic [2:0] {
    CSL_IDLE = 3'b000,
    CSL_LOAD = 3'b001,
    CSL_CAL = 3'b010,
    CSL_LOCK = 3'b011,
    CSL_SYNC = 3'b100,
    CSL_RUN = 3'b101
  } csl_state_t;
endpackage
`default_nettype wire

//--- csl_page_reader.sv
`default_nettype none
// Walks the stored page word by word; the store answers one cycle after an index.
module csl_page_reader #(
  parameter int unsigned WORDS = csl_pkg::PAGE_WORDS
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  output logic [csl_pkg::IDX_W-1:0] o_idx,
  output logic o_word_valid,
  output logic [csl_pkg::IDX_W-1:0] o_word_idx,
  output logic o_done
);
  logic busy, next_busy;
  logic [csl_pkg::IDX_W-1:0] idx, next_idx;
  logic vld, next_vld;
  logic [csl_pkg::IDX_W-1:0] widx, next_widx;
  logic last, next_last;
  logic done, next_done;

  always_comb begin
    next_busy = busy;
    next_idx = idx;
    next_vld = busy;
    next_widx = idx;
    next_last = busy && (idx == csl_pkg::IDX_W'(WORDS - 1));
    next_done = last;
    if (i_start && !busy) begin
      next_busy = 1'b1;
      next_idx = '0;
    end else if (busy) begin
      if (idx == csl_pkg::IDX_W'(WORDS - 1)) begin
        next_busy = 1'b0;
      end else begin
        next_idx = idx + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy <= 1'b0;
      idx <= '0;
      vld <= 1'b0;
      widx <= '0;
      last <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= next_busy;
      idx <= next_idx;
      vld <= next_vld;
      widx <= next_widx;
      last <= next_last;
      done <= next_done;
    end
  end

  assign o_idx = idx;
  assign o_word_valid = vld;
  assign o_word_idx = widx;
  assign o_done = done;
endmodule
`default_nettype wire

//--- csl_startup_loader.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`default_nettype none
// What this block does
// - After power-on release, copy stored words into registers, then apply them.
// - Page-select pin low loads page 0, high loads page 1.
// - Keep differential outputs muted during VCO calibration and PLL lock.
// - After lock, synchronize all output dividers first, then release them.
// - Hold pin low keeps sequence start and serial interface in reset.
// - With hold pin reassigned, start only from the power-on release or a control-register reload.
// - Pin functions and directions come from the loaded page registers.
// - A stored field selects pin mode or serial-interface mode.
module csl_startup_loader #(
  parameter int unsigned N_PINS = csl_pkg::N_PINS,
  parameter int unsigned N_CH = csl_pkg::N_CH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_por_release,
  input wire logic i_config_page_select_pin,
  input wire logic i_chip_hold_low_pin_n,
  output logic [csl_pkg::IDX_W-1:0] o_store_idx,
  output logic o_store_page,
  input wire logic [csl_pkg::WORD_W-1:0] i_store_data,
  output logic o_cal_start,
  input wire logic i_cal_done,
  input wire logic i_pll_locked,
  output logic o_outputs_muted,
  output logic o_div_sync,
  output logic o_div_release,
  output logic o_serial_rst,
  output logic o_serial_mode,
  output logic [N_PINS-1:0] o_pin_dir,
  output logic [N_PINS-1:0] o_pin_fn,
  output logic [N_CH*csl_pkg::DIV_W-1:0] o_channel_output_divider,
  output logic [csl_pkg::PRESC_W-1:0] o_vco_prescaler,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  csl_pkg::csl_state_t state, next_state;
  logic page, next_page;
  logic loaded, next_loaded;
  logic [3:0] sync_cnt, next_sync_cnt;
  logic rd_start, rd_vld, rd_done;
  logic [csl_pkg::IDX_W-1:0] rd_widx;
  logic [csl_pkg::WORD_W-1:0] gcfg, next_gcfg;
  logic [N_CH*csl_pkg::DIV_W-1:0] divs, next_divs;
  logic [csl_pkg::PRESC_W-1:0] presc, next_presc;
  logic reload_req, mute_force;
  logic hold_en, held;

  // The hold pin only counts while the loaded word still assigns it that function.
  assign hold_en = gcfg[csl_pkg::GCFG_HOLD_EN_BIT];
  assign held = hold_en && !i_chip_hold_low_pin_n;

  always_comb begin
    next_state = state;
    next_page = page;
    next_loaded = loaded;
    next_sync_cnt = sync_cnt;
    rd_start = 1'b0;
    case (state)
      csl_pkg::CSL_IDLE: begin
        if ((i_por_release || reload_req) && !held) begin
          next_page = i_config_page_select_pin;
          next_loaded = 1'b0;
          rd_start = 1'b1;
          next_state = csl_pkg::CSL_LOAD;
        end
      end
      csl_pkg::CSL_LOAD: begin
        if (rd_done) begin
          next_loaded = 1'b1;
          next_state = csl_pkg::CSL_CAL;
        end
      end
      csl_pkg::CSL_CAL: begin
        // Done may still be high from the last run until the start pulse is seen.
        if (i_cal_done && !o_cal_start) begin
          next_state = csl_pkg::CSL_LOCK;
        end
      end
      csl_pkg::CSL_LOCK: begin
        if (i_pll_locked) begin
          next_sync_cnt = '0;
          next_state = csl_pkg::CSL_SYNC;
        end
      end
      csl_pkg::CSL_SYNC: begin
        next_sync_cnt = sync_cnt + 1'b1;
        if (sync_cnt == csl_pkg::SYNC_CYCLES - 1'b1) begin
          next_state = csl_pkg::CSL_RUN;
        end
      end
      csl_pkg::CSL_RUN: begin
        // The reload pulse lasts one cycle, so the load starts here; a detour through
        // idle would drop it and leave the outputs muted for good.
        if (reload_req && !held) begin
          next_page = i_config_page_select_pin;
          next_loaded = 1'b0;
          rd_start = 1'b1;
          next_state = csl_pkg::CSL_LOAD;
        end
      end
      default: next_state = csl_pkg::CSL_IDLE;
    endcase
    // While gcfg assigns the hold function, a low hold pin sends the sequencer back to idle and keeps it there.
    if (held) begin
      next_state = csl_pkg::CSL_IDLE;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= csl_pkg::CSL_IDLE;
      page <= 1'b0;
      loaded <= 1'b0;
      sync_cnt <= '0;
    end else begin
      state <= next_state;
      page <= next_page;
      loaded <= next_loaded;
      sync_cnt <= next_sync_cnt;
    end
  end

  csl_page_reader #(
    .WORDS(csl_pkg::PAGE_WORDS)
  ) u_reader (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(rd_start),
    .o_idx(o_store_idx),
    .o_word_valid(rd_vld),
    .o_word_idx(rd_widx),
    .o_done(rd_done)
  );
  assign o_store_page = page;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic apb_wr, apb_rd;
  logic wr_ok;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && i_penable && !i_pwrite;
  assign wr_ok = apb_wr && loaded && state != csl_pkg::CSL_LOAD;

  always_comb begin
    next_gcfg = gcfg;
    next_divs = divs;
    next_presc = presc;
    if (rd_vld) begin
      if (rd_widx == csl_pkg::W_GCFG) begin
        next_gcfg = i_store_data;
      end
      if (rd_widx == csl_pkg::W_PRESC) begin
        next_presc = i_store_data[csl_pkg::PRESC_W-1:0];
      end
    end
    for (int c = 0; c < N_CH; c++) begin
      if (rd_vld && rd_widx == csl_pkg::IDX_W'(csl_pkg::W_DIV_LSB + c)) begin
        next_divs[c*csl_pkg::DIV_W +: csl_pkg::DIV_W] = i_store_data[csl_pkg::DIV_W-1:0];
      end
      if (wr_ok && i_paddr == 8'(csl_pkg::OFF_DIV + 4 * c)) begin
        next_divs[c*csl_pkg::DIV_W +: csl_pkg::DIV_W] = i_pwdata[csl_pkg::DIV_W-1:0];
      end
    end
    if (wr_ok && i_paddr == csl_pkg::OFF_GCFG) begin
      next_gcfg = i_pwdata[csl_pkg::WORD_W-1:0];
    end
    if (wr_ok && i_paddr == csl_pkg::OFF_PRESC) begin
      next_presc = i_pwdata[csl_pkg::PRESC_W-1:0];
    end
  end

  logic next_reload, next_mute_force;
  always_comb begin
    next_reload = 1'b0;
    next_mute_force = mute_force;
    if (wr_ok && i_paddr == csl_pkg::OFF_CTRL) begin
      next_reload = i_pwdata[csl_pkg::CTRL_RELOAD_BIT];
      next_mute_force = i_pwdata[csl_pkg::CTRL_MUTE_FORCE_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gcfg <= csl_pkg::GCFG_RESET;
      divs <= '0;
      presc <= '0;
      reload_req <= 1'b0;
      mute_force <= 1'b0;
    end else begin
      gcfg <= next_gcfg;
      divs <= next_divs;
      presc <= next_presc;
      reload_req <= next_reload;
      mute_force <= next_mute_force;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic next_muted, next_sync, next_release, next_srst, next_cal;

  always_comb begin
    next_muted = (state != csl_pkg::CSL_RUN) || mute_force;
    next_sync = (state == csl_pkg::CSL_SYNC);
    next_release = (state == csl_pkg::CSL_RUN);
    next_srst = held;
    next_cal = (state == csl_pkg::CSL_LOAD) && rd_done;
    next_prdata = '0;
    if (apb_rd) begin
      case (i_paddr)
        csl_pkg::OFF_CTRL: next_prdata = 32'({mute_force, 1'b0});
        csl_pkg::OFF_STATUS: next_prdata = 32'({i_pll_locked, page, loaded, state});
        csl_pkg::OFF_GCFG: next_prdata = 32'(gcfg);
        csl_pkg::OFF_PINDIR: next_prdata = 32'(o_pin_dir);
        csl_pkg::OFF_PINFN: next_prdata = 32'(o_pin_fn);
        csl_pkg::OFF_PRESC: next_prdata = 32'(presc);
        default: begin
          for (int c = 0; c < N_CH; c++) begin
            if (i_paddr == 8'(csl_pkg::OFF_DIV + 4 * c)) begin
              next_prdata = 32'(divs[c*csl_pkg::DIV_W +: csl_pkg::DIV_W]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_outputs_muted <= 1'b1;
      o_div_sync <= 1'b0;
      o_div_release <= 1'b0;
      o_serial_rst <= 1'b1;
      o_cal_start <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_outputs_muted <= next_muted;
      o_div_sync <= next_sync;
      o_div_release <= next_release;
      o_serial_rst <= next_srst;
      o_cal_start <= next_cal;
      o_prdata <= next_prdata;
    end
  end

  assign o_serial_mode = gcfg[csl_pkg::GCFG_MODE_BIT];
  assign o_pin_dir = gcfg[csl_pkg::GCFG_DIR_LSB +: N_PINS];
  assign o_pin_fn = gcfg[csl_pkg::GCFG_FN_LSB +: N_PINS];
  assign o_channel_output_divider = divs;
  assign o_vco_prescaler = presc;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_locked_in_lock;
    state == csl_pkg::CSL_LOCK && i_pll_locked && !held;
  endsequence
  sequence s_sync_then_release;
    o_div_sync [*4] ##1 o_div_release;
  endsequence

  a_load_then_cal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == csl_pkg::CSL_LOAD && rd_done) |=> state == csl_pkg::CSL_CAL && loaded)
    else $error("Load end did not move to calibration.");
  a_page_from_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_start |=> page == $past(i_config_page_select_pin))
    else $error("Wrong page selected.");
  a_mute_until_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state != csl_pkg::CSL_RUN) |=> o_outputs_muted)
    else $error("Outputs unmuted before run.");
  a_sync_before_go: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_locked_in_lock ##1 !held [*6]) |-> o_div_release && $past(o_div_sync) &&
      !$past(o_div_release))
    else $error("Sync order broken.");
  a_sync_release_seq: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($rose(o_div_sync) && !held ##1 !held [*4]) |-> $past(o_div_sync, 3) ##1 o_div_release)
    else $error("Release did not follow sync.");
  a_sync_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_sync_then_release |-> !$past(o_div_sync, 5))
    else $error("Sync ran longer than its count.");
  a_hold_resets_serial: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    held |=> o_serial_rst && state == csl_pkg::CSL_IDLE)
    else $error("Hold did not reset.");
  a_start_on_por: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_start |-> (i_por_release || reload_req) && !held)
    else $error("Start without release.");
  a_pin_dir_map: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (rd_vld && rd_widx == csl_pkg::W_GCFG) |=> o_pin_dir == $past(i_store_data[6:2]))
    else $error("Pin direction not loaded.");
  a_mode_loaded: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (rd_vld && rd_widx == csl_pkg::W_GCFG) |=> o_serial_mode == $past(i_store_data[0]))
    else $error("Mode not loaded.");
  a_write_blocked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (apb_wr && !loaded && i_paddr == csl_pkg::OFF_GCFG && !rd_vld) |=> $stable(gcfg))
    else $error("Write landed before load.");
endmodule
`default_nettype wire

//--- csl_store_model.sv
`default_nettype none
// ----------------------------------------
// Stored pages and analog start-up stand-in
// ----------------------------------------
// The store answers the index of the previous cycle, as the real array does.
// Calibration and lock delays are set by the bench so that runs are both quick and slow.
module csl_store_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [csl_pkg::IDX_W-1:0] i_idx,
  input wire logic i_page,
  input wire logic i_cal_start,
  output logic [csl_pkg::WORD_W-1:0] o_data,
  output logic o_cal_done,
  output logic o_pll_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [csl_pkg::WORD_W-1:0] mem [2][16];
  int starts;
  int cnt;
  int cal_wait = 3;
  int lock_wait = 2;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= 16'h0000;
      o_cal_done <= 1'b0;
      o_pll_locked <= 1'b0;
      cnt <= 0;
      starts <= 0;
    end else begin
      o_data <= mem[i_page][i_idx];
      if (i_cal_start) begin
        starts <= starts + 1;
        cnt <= 0;
        o_cal_done <= 1'b0;
        o_pll_locked <= 1'b0;
      end else if (starts != 0) begin
        cnt <= cnt + 1;
        if (cnt == cal_wait) o_cal_done <= 1'b1;
        if (cnt == cal_wait + lock_wait) o_pll_locked <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_sys_rst, por, pg, hold_n, psel, pen, pwr, spage, cst, cdone, plock;
  logic mute, dsync, drel, srst, smode, prdy, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] sidx;
  logic [15:0] sdata;
  logic [4:0] pdir, pfn;
  logic [55:0] divs;
  logic [1:0] presc;
  logic rd_look;
  logic [31:0] expq [$];
  int miscompares, samples_checked, st;
  logic [31:0] r;
  csl_startup_loader DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por_release(por),
    .i_config_page_select_pin(pg), .i_chip_hold_low_pin_n(hold_n), .o_store_idx(sidx),
    .o_store_page(spage), .i_store_data(sdata), .o_cal_start(cst), .i_cal_done(cdone),
    .i_pll_locked(plock), .o_outputs_muted(mute), .o_div_sync(dsync), .o_div_release(drel),
    .o_serial_rst(srst), .o_serial_mode(smode), .o_pin_dir(pdir), .o_pin_fn(pfn),
    .o_channel_output_divider(divs), .o_vco_prescaler(presc), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr));
  csl_store_model mdl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_idx(sidx), .i_page(spage),
    .i_cal_start(cst), .o_data(sdata), .o_cal_done(cdone), .o_pll_locked(plock));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Read data is registered at the access edge, so it is taken one edge later.
  always @(posedge i_clk) begin
    if (rd_look) check("prdata", prdata, expq.pop_front());
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (prdy !== 1'b1);
    check("pslverr", perr, 1'b0);
    psel <= 1'b0;
    pen <= 1'b0;
    if (!w) begin
      expq.push_back(d);
      rd_look <= 1'b1;
      @(posedge i_clk);
      rd_look <= 1'b0;
    end
  endtask
  task automatic run_load(input logic p, input logic via_ctrl);
    int n;
    logic [15:0] g;
    g = mdl.mem[p][0];
    @(posedge i_clk);
    pg <= p;
    if (via_ctrl) begin
      apb(1'b1, csl_pkg::OFF_CTRL, 32'h00000001);
    end else begin
      por <= 1'b1;
      @(posedge i_clk);
      por <= 1'b0;
    end
    n = 0;
    while (cst !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    check("page", spage, p);
    n = 0;
    while (dsync !== 1'b1 && n < 500) begin
      check("mute_cal", mute, 1'b1);
      @(negedge i_clk);
      n++;
    end
    n = 0;
    while (dsync === 1'b1 && n < 20) begin
      check("rel_sync", drel, 1'b0);
      @(negedge i_clk);
      n++;
    end
    check("sync_len", n, 32'(csl_pkg::SYNC_CYCLES));
    check("release", drel, 1'b1);
    check("unmute", mute, 1'b0);
    check("mode", smode, g[0]);
    check("dir", pdir, g[6:2]);
    check("fn", pfn, g[11:7]);
    for (int c = 0; c < 4; c++) check("div", divs[c*14 +: 14], mdl.mem[p][c+1][13:0]);
    check("presc", presc, mdl.mem[p][5][1:0]);
  endtask
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {por, pg, psel, pen, pwr, rd_look} = '0;
    hold_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    i_sys_rst = 1'b1;
    st = $urandom(32'hdb91);
    // legal plan: divider 1..16383, prescaler 0..2.
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 16; w++) mdl.mem[p][w] = 16'($urandom);
      mdl.mem[p][0][1] = p[0];
      for (int w = 1; w < 5; w++) mdl.mem[p][w][13:0] = 14'(1 + $urandom % 16383);
      mdl.mem[p][5] = 16'($urandom % 3);
    end
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    check("rst_mute", mute, 1'b1);
    check("rst_srst", srst, 1'b1);
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(negedge i_clk);
    check("srst_idle", srst, 1'b0);
    apb(1'b1, csl_pkg::OFF_GCFG, 32'h0000001D);
    apb(1'b0, csl_pkg::OFF_GCFG, 32'h00000002);
    mdl.cal_wait = 40;
    mdl.lock_wait = 25;
    run_load(1'b1, 1'b0);
    apb(1'b0, csl_pkg::OFF_GCFG, {16'h0000, mdl.mem[1][0]});
    apb(1'b0, 8'hFC, 32'h00000000);
    apb(1'b0, csl_pkg::OFF_STATUS, 32'h0000003D);
    // Bit 1 stays set so that the hold pin keeps its function for the next scenario.
    r = $urandom | 32'h00000002;
    apb(1'b1, csl_pkg::OFF_GCFG, r);
    @(negedge i_clk);
    check("dir_wr", pdir, r[6:2]);
    check("fn_wr", pfn, r[11:7]);
    check("mode_wr", smode, r[0]);
    r = 1 + $urandom % 16383;
    apb(1'b1, csl_pkg::OFF_DIV, r);
    @(negedge i_clk);
    check("div_wr", divs[13:0], r[13:0]);
    apb(1'b0, csl_pkg::OFF_DIV, r);
    apb(1'b1, csl_pkg::OFF_CTRL, 32'h00000002);
    repeat (2) @(negedge i_clk);
    check("force_mute", mute, 1'b1);
    apb(1'b1, csl_pkg::OFF_CTRL, 32'h00000000);
    repeat (2) @(negedge i_clk);
    check("force_off", mute, 1'b0);
    @(posedge i_clk);
    hold_n <= 1'b0;
    st = mdl.starts;
    repeat (3) @(negedge i_clk);
    check("hold_srst", srst, 1'b1);
    check("hold_rel", drel, 1'b0);
    @(posedge i_clk);
    por <= 1'b1;
    @(posedge i_clk);
    por <= 1'b0;
    repeat (40) @(negedge i_clk);
    check("hold_start", mdl.starts, st);
    @(posedge i_clk);
    hold_n <= 1'b1;
    mdl.cal_wait = 1;
    mdl.lock_wait = 0;
    run_load(1'b0, 1'b0);
    @(posedge i_clk);
    hold_n <= 1'b0;
    repeat (5) @(negedge i_clk);
    check("nohold_srst", srst, 1'b0);
    check("nohold_rel", drel, 1'b1);
    @(posedge i_clk);
    hold_n <= 1'b1;
    run_load(1'b1, 1'b1);
    repeat (3) @(posedge i_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
